/* File: piso_ctrl_model.sv */
// Model of the outside control logic that drives the shift block's pins.
`timescale 1ns/10ps
`default_nettype none

module piso_ctrl_model
(
  input  wire logic         CLK_IN,
  output var  piso_pkg::pin_bus_s PINS_OUT
);
  initial PINS_OUT = piso_pkg::PIN_BUS_RST;
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask : tick
  // Enable settles well before the next shift edge.
  task automatic mode(input logic en_n, input logic drv_n);
    PINS_OUT.shift_clock_enable_n <= en_n;
    PINS_OUT.output_drive_n <= drv_n;
    tick(5);
  endtask : mode
  task automatic capture(input logic [7:0] w);
    PINS_OUT.parallel_data <= w;
    PINS_OUT.stage_ports <= w;
    tick(2);
    PINS_OUT.storage_capture_clock <= 1'b1;
    tick(3);
    PINS_OUT.storage_capture_clock <= 1'b0;
    PINS_OUT.parallel_data <= ~w;
    PINS_OUT.stage_ports <= ~w;
    tick(4);
  endtask : capture
  // Capture always ends at least 40 ns before load is released.
  task automatic load();
    PINS_OUT.parallel_load_n <= 1'b0;
    tick(6);
    PINS_OUT.parallel_load_n <= 1'b1;
    tick(4);
  endtask : load
  task automatic clear();
    PINS_OUT.shift_clear_n <= 1'b0;
    tick(4);
    PINS_OUT.shift_clear_n <= 1'b1;
    tick(4);
  endtask : clear
  // The unselected source carries the inverse, so a wrong pick shows.
  task automatic shift(input logic b, input logic sel);
    PINS_OUT.serial_source_select <= sel;
    PINS_OUT.shift_data_in <= sel ? ~b : b;
    PINS_OUT.stage_ports[0] <= sel ? b : ~b;
    tick(3);
    PINS_OUT.shift_clock_in <= 1'b1;
    tick(2);
    PINS_OUT.shift_clock_in <= 1'b0;
    PINS_OUT.shift_data_in <= ~PINS_OUT.shift_data_in;
    tick(4);
  endtask : shift
endmodule : piso_ctrl_model
`default_nettype wire

/* File: piso_pin_sync.sv */
// Two-flop synchroniser for every pin of the shift block.
`timescale 1ns/10ps
`default_nettype none

module piso_pin_sync
(
  input  wire logic              CLK_IN,
  input  wire logic              NRST_IN,
  input  wire piso_pkg::pin_bus_s pins_in,
  output var  piso_pkg::pin_bus_s pins_out
);

  piso_pkg::sync_state_s state_q;
  piso_pkg::sync_state_s state_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The first stage feeds only the second, to let metastability settle.
  always_comb
  begin
    state_d        = state_q;
    state_d.first  = pins_in;
    state_d.second = state_q.first;
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      state_q <= '{first: piso_pkg::PIN_BUS_RST, second: piso_pkg::PIN_BUS_RST};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pins_out = state_q.second;

endmodule : piso_pin_sync

`default_nettype wire

/* File: piso_pkg.sv */
// Types shared by the shift block and its pin synchroniser.
`default_nettype none

package piso_pkg;

  // ----------------------------------------------------------------
  // Pin group, sampled together so that all pins see the same latency
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] parallel_data;
    logic [7:0] stage_ports;
    logic       storage_capture_clock;
    logic       shift_clock_in;
    logic       parallel_load_n;
    logic       shift_clear_n;
    logic       shift_clock_enable_n;
    logic       shift_data_in;
    logic       serial_source_select;
    logic       output_drive_n;
  } pin_bus_s;

  localparam pin_bus_s PIN_BUS_RST = '{
    parallel_data:         8'h00,
    stage_ports:           8'h00,
    storage_capture_clock: 1'b0,
    shift_clock_in:        1'b0,
    parallel_load_n:       1'b1,
    shift_clear_n:         1'b1,
    shift_clock_enable_n:  1'b1,
    shift_data_in:         1'b0,
    serial_source_select:  1'b0,
    output_drive_n:        1'b1
  };

  typedef struct packed {
    pin_bus_s first;
    pin_bus_s second;
  } sync_state_s;

  typedef struct packed {
    logic       ext_mode;
    logic       soft_clear;
    logic [7:0] storage;
    logic [7:0] stages;
    logic       cap_prev;
    logic       shift_prev;
    logic       ports_oe_n;
    logic       aw_held;
    logic [3:0] aw_addr;
    logic       w_held;
    logic [1:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } core_state_s;

endpackage : piso_pkg

`default_nettype wire

/* File: piso_regs.svh */
// Register offsets, field positions, reset values and timing counts of the shift block.
`ifndef PISO_REGS_SVH
`define PISO_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PISO_CTRL_OFFSET        4'h0
`define PISO_STATUS_OFFSET      4'h4
`define PISO_ADDR_BITS          4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PISO_CTRL_EXT_BIT       0
`define PISO_CTRL_SCLR_BIT      1
`define PISO_STATUS_STORE_LSB   0
`define PISO_STATUS_SHIFT_LSB   8
`define PISO_STATUS_LAST_BIT    16
`define PISO_STATUS_OE_N_BIT    17

// ----------------------------------------------------------------
// Reset values and response codes
// ----------------------------------------------------------------
`define PISO_CTRL_EXT_RST       1'b0
`define PISO_CTRL_SCLR_RST      1'b0
`define PISO_WORD_RST           8'h00
`define PISO_RESP_OKAY          2'b00
`define PISO_RESP_SLVERR        2'b10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PISO_CLK_MHZ            100
`define PISO_SHIFT_MAX_MHZ      20
`define PISO_SHIFT_MIN_CYCLES   ((`PISO_CLK_MHZ + `PISO_SHIFT_MAX_MHZ - 1) / `PISO_SHIFT_MAX_MHZ)

`endif

/* File: piso_shift_core.sv */
// Storage register feeding an eight-stage parallel-in serial-out shift register.
// ----------------------------------------------------------------
// Function
// - An 8-bit storage register captures the parallel input word, or the stage ports in extended mode, and feeds the shift stages.
// - An 8-bit shift register loads in parallel and leaves one bit at a time on one output.
// - Storage updates only on a capture clock rise, stages shift only on a shift clock rise.
// - Low parallel load copies storage into all stages at once and beats shifting.
// - Low shift clear zeroes every stage at once, beats shifting, and drives the output low.
// - In extended mode the stages drive three-state ports enabled by a low drive input.
// - In extended mode a select input sampled at the shift edge picks the serial source.
// - In extended mode a shift edge advances the stages only while the enable is low.
// - The stages work at any shift rate up to 20 MHz and hold their value between edges.
// ----------------------------------------------------------------
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "piso_regs.svh"

module piso_shift_core
(
  input  wire logic        CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic [7:0]  PARALLEL_DATA_IN,
  input  wire logic        STORAGE_CAPTURE_CLOCK_IN,
  input  wire logic        SHIFT_CLOCK_IN,
  input  wire logic        PARALLEL_LOAD_N_IN,
  input  wire logic        SHIFT_CLEAR_N_IN,
  input  wire logic        SHIFT_CLOCK_ENABLE_N_IN,
  input  wire logic        SHIFT_DATA_IN,
  input  wire logic        SERIAL_SOURCE_SELECT_IN,
  input  wire logic        OUTPUT_DRIVE_N_IN,
  input  wire logic [7:0]  STAGE_PORTS_IN,
  output var  logic [7:0]  STAGE_PORTS_OUT,
  output var  logic [7:0]  STAGE_PORTS_OE_N_OUT,
  output var  logic        LAST_STAGE_OUT,
  input  wire logic [3:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output var  logic        AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output var  logic        WREADY_OUT,
  output var  logic [1:0]  BRESP_OUT,
  output var  logic        BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [3:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output var  logic        ARREADY_OUT,
  output var  logic [31:0] RDATA_OUT,
  output var  logic [1:0]  RRESP_OUT,
  output var  logic        RVALID_OUT,
  input  wire logic        RREADY_IN
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  piso_pkg::pin_bus_s pins_raw;
  piso_pkg::pin_bus_s pins;

  always_comb
  begin
    pins_raw.parallel_data         = PARALLEL_DATA_IN;
    pins_raw.stage_ports           = STAGE_PORTS_IN;
    pins_raw.storage_capture_clock = STORAGE_CAPTURE_CLOCK_IN;
    pins_raw.shift_clock_in        = SHIFT_CLOCK_IN;
    pins_raw.parallel_load_n       = PARALLEL_LOAD_N_IN;
    pins_raw.shift_clear_n         = SHIFT_CLEAR_N_IN;
    pins_raw.shift_clock_enable_n  = SHIFT_CLOCK_ENABLE_N_IN;
    pins_raw.shift_data_in         = SHIFT_DATA_IN;
    pins_raw.serial_source_select  = SERIAL_SOURCE_SELECT_IN;
    pins_raw.output_drive_n        = OUTPUT_DRIVE_N_IN;
  end

  piso_pin_sync u_pin_sync
  (
    .CLK_IN   (CLK_IN),
    .NRST_IN  (NRST_IN),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {REG_CTRL = 2'b00, REG_STATUS = 2'b01, REG_NONE = 2'b11} reg_sel_e;

  function automatic reg_sel_e decode(input logic [3:0] addr);
    reg_sel_e sel;
    sel = REG_NONE;
    case (addr)
      `PISO_CTRL_OFFSET:   sel = REG_CTRL;
      `PISO_STATUS_OFFSET: sel = REG_STATUS;
      default:             sel = REG_NONE;
    endcase
    return sel;
  endfunction : decode

  piso_pkg::core_state_s state_q;
  piso_pkg::core_state_s state_d;

  logic        cap_edge;
  logic        shift_edge;
  logic        clear_active;
  logic        load_active;
  logic        serial_bit;
  logic [7:0]  capture_word;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        aw_have;
  logic        w_have;
  logic [3:0]  wr_addr;
  logic [1:0]  wr_bits;
  logic        wr_lane0;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  // Only one write and one read are in flight, so each channel is held off
  // while its response is still waiting.
  assign AWREADY_OUT = !state_q.aw_held && !state_q.bvalid;
  assign WREADY_OUT  = !state_q.w_held && !state_q.bvalid;
  assign ARREADY_OUT = !state_q.rvalid;

  assign aw_take  = AWVALID_IN && AWREADY_OUT;
  assign w_take   = WVALID_IN && WREADY_OUT;
  assign ar_take  = ARVALID_IN && ARREADY_OUT;
  assign aw_have  = aw_take || state_q.aw_held;
  assign w_have   = w_take || state_q.w_held;
  assign wr_addr  = state_q.aw_held ? state_q.aw_addr : AWADDR_IN;
  assign wr_bits  = state_q.w_held ? state_q.w_data : WDATA_IN[1:0];
  assign wr_lane0 = state_q.w_held ? state_q.w_lane0 : WSTRB_IN[0];

  // ----------------------------------------------------------------
  // Shift path control
  // ----------------------------------------------------------------
  // Pin clocks are sampled, so edges closer than two system cycles apart are
  // not resolved; the 20 MHz ceiling leaves PISO_SHIFT_MIN_CYCLES of margin.
  assign cap_edge     = pins.storage_capture_clock && !state_q.cap_prev;
  assign shift_edge   = pins.shift_clock_in && !state_q.shift_prev
                        && (!state_q.ext_mode || !pins.shift_clock_enable_n);
  assign clear_active = !pins.shift_clear_n || state_q.soft_clear;
  assign load_active  = !pins.parallel_load_n;
  assign serial_bit   = (state_q.ext_mode && pins.serial_source_select)
                        ? pins.stage_ports[0] : pins.shift_data_in;
  assign capture_word = state_q.ext_mode ? pins.stage_ports : pins.parallel_data;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`PISO_STATUS_STORE_LSB +: 8] = state_q.storage;
    status_word[`PISO_STATUS_SHIFT_LSB +: 8] = state_q.stages;
    status_word[`PISO_STATUS_LAST_BIT]       = state_q.stages[7];
    status_word[`PISO_STATUS_OE_N_BIT]       = state_q.ports_oe_n;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d            = state_q;
    state_d.cap_prev   = pins.storage_capture_clock;
    state_d.shift_prev = pins.shift_clock_in;

    if (cap_edge)
    begin
      state_d.storage = capture_word;
    end

    // Clear beats load, and both beat a shift edge; without either the
    // stages simply hold, however long the shift clock stands still.
    if (clear_active)
    begin
      state_d.stages = `PISO_WORD_RST;
    end
    else if (load_active)
    begin
      state_d.stages = state_q.storage;
    end
    else if (shift_edge)
    begin
      state_d.stages = {state_q.stages[6:0], serial_bit};
    end

    state_d.ports_oe_n = !(state_q.ext_mode && !pins.output_drive_n);

    if (aw_take)
    begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = AWADDR_IN;
    end
    if (w_take)
    begin
      state_d.w_held  = 1'b1;
      state_d.w_data  = WDATA_IN[1:0];
      state_d.w_lane0 = WSTRB_IN[0];
    end
    if (aw_have && w_have)
    begin
      state_d.aw_held = 1'b0;
      state_d.w_held  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = `PISO_RESP_OKAY;
      case (decode(wr_addr))
        REG_CTRL:
        begin
          if (wr_lane0)
          begin
            state_d.ext_mode   = wr_bits[`PISO_CTRL_EXT_BIT];
            state_d.soft_clear = wr_bits[`PISO_CTRL_SCLR_BIT];
          end
        end
        REG_STATUS: state_d.bresp = `PISO_RESP_OKAY;
        default:    state_d.bresp = `PISO_RESP_SLVERR;
      endcase
    end
    else if (state_q.bvalid && BREADY_IN)
    begin
      state_d.bvalid = 1'b0;
    end

    if (ar_take)
    begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = `PISO_RESP_OKAY;
      case (decode(ARADDR_IN))
        REG_CTRL:
        begin
          state_d.rdata = 32'h0000_0000;
          state_d.rdata[`PISO_CTRL_EXT_BIT]  = state_q.ext_mode;
          state_d.rdata[`PISO_CTRL_SCLR_BIT] = state_q.soft_clear;
        end
        REG_STATUS: state_d.rdata = status_word;
        default:
        begin
          state_d.rdata = 32'h0000_0000;
          state_d.rresp = `PISO_RESP_SLVERR;
        end
      endcase
    end
    else if (state_q.rvalid && RREADY_IN)
    begin
      state_d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      state_q <= '{
        ext_mode:   `PISO_CTRL_EXT_RST,
        soft_clear: `PISO_CTRL_SCLR_RST,
        storage:    `PISO_WORD_RST,
        stages:     `PISO_WORD_RST,
        cap_prev:   1'b0,
        shift_prev: 1'b0,
        ports_oe_n: 1'b1,
        aw_held:    1'b0,
        aw_addr:    4'h0,
        w_held:     1'b0,
        w_data:     2'b00,
        w_lane0:    1'b0,
        bvalid:     1'b0,
        bresp:      `PISO_RESP_OKAY,
        rvalid:     1'b0,
        rdata:      32'h0000_0000,
        rresp:      `PISO_RESP_OKAY
      };
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign LAST_STAGE_OUT       = state_q.stages[7];
  assign STAGE_PORTS_OUT      = state_q.stages;
  assign STAGE_PORTS_OE_N_OUT = {8{state_q.ports_oe_n}};
  assign BVALID_OUT           = state_q.bvalid;
  assign BRESP_OUT            = state_q.bresp;
  assign RVALID_OUT           = state_q.rvalid;
  assign RDATA_OUT            = state_q.rdata;
  assign RRESP_OUT            = state_q.rresp;

endmodule : piso_shift_core

`default_nettype wire

/* File: piso_shift_core_sva.sv */
// Checker of the shift block's pin-side behaviour.
`timescale 1ns/10ps
`default_nettype none

module piso_shift_core_sva
(
  input wire logic       CLK_IN,
  input wire logic       NRST_IN,
  input wire logic       SHIFT_CLOCK_IN,
  input wire logic       PARALLEL_LOAD_N_IN,
  input wire logic       SHIFT_CLEAR_N_IN,
  input wire logic       SHIFT_CLOCK_ENABLE_N_IN,
  input wire logic       SHIFT_DATA_IN,
  input wire logic       SERIAL_SOURCE_SELECT_IN,
  input wire logic       OUTPUT_DRIVE_N_IN,
  input wire logic       STORAGE_CAPTURE_CLOCK_IN,
  input wire logic [7:0] STAGE_PORTS_OUT,
  input wire logic [7:0] STAGE_PORTS_OE_N_OUT,
  input wire logic       LAST_STAGE_OUT,
  input wire logic       BVALID_OUT
);
  // Pins pass a two-flop synchroniser, so effects land three samples later.
  wire logic shift_ok;
  assign shift_ok = !SHIFT_CLOCK_ENABLE_N_IN && PARALLEL_LOAD_N_IN && SHIFT_CLEAR_N_IN;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_clear;
    (!SHIFT_CLEAR_N_IN)[*4] |-> STAGE_PORTS_OUT == 8'h00 && !LAST_STAGE_OUT;
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_last;
    $rose(SHIFT_CLOCK_IN) && shift_ok |-> ##3 LAST_STAGE_OUT == $past(STAGE_PORTS_OUT[6]);
  endproperty
  a_last: assert property (p_last) else $error("last stage");
  // A release follows a high drive pin, or a register write that left extended mode.
  property p_oe_off;
    $rose(STAGE_PORTS_OE_N_OUT[0]) |-> $past(OUTPUT_DRIVE_N_IN, 3) || $past(BVALID_OUT);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("release");
  property p_oe_on;
    $fell(STAGE_PORTS_OE_N_OUT[0]) |-> $past(OUTPUT_DRIVE_N_IN, 3) == 1'b0;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("drive");
  property p_shift;
    $rose(SHIFT_CLOCK_IN) && shift_ok |-> ##3 STAGE_PORTS_OUT[7:1] == $past(STAGE_PORTS_OUT[6:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift");
  property p_serial;
    $rose(SHIFT_CLOCK_IN) && shift_ok && !SERIAL_SOURCE_SELECT_IN
      |-> ##3 STAGE_PORTS_OUT[0] == $past(SHIFT_DATA_IN, 3);
  endproperty
  a_serial: assert property (p_serial) else $error("serial");
  property p_hold;
    (!SHIFT_CLOCK_IN && PARALLEL_LOAD_N_IN && SHIFT_CLEAR_N_IN && !BVALID_OUT)[*5]
      |-> $stable(STAGE_PORTS_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_load;
    (!PARALLEL_LOAD_N_IN && SHIFT_CLEAR_N_IN && !STORAGE_CAPTURE_CLOCK_IN && !BVALID_OUT)[*5]
      |-> $stable(STAGE_PORTS_OUT);
  endproperty
  a_load: assert property (p_load) else $error("load");
endmodule : piso_shift_core_sva

bind piso_shift_core piso_shift_core_sva u_sva
(
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .SHIFT_CLOCK_IN(SHIFT_CLOCK_IN),
  .PARALLEL_LOAD_N_IN(PARALLEL_LOAD_N_IN), .SHIFT_CLEAR_N_IN(SHIFT_CLEAR_N_IN),
  .SHIFT_CLOCK_ENABLE_N_IN(SHIFT_CLOCK_ENABLE_N_IN), .SHIFT_DATA_IN(SHIFT_DATA_IN),
  .SERIAL_SOURCE_SELECT_IN(SERIAL_SOURCE_SELECT_IN), .OUTPUT_DRIVE_N_IN(OUTPUT_DRIVE_N_IN),
  .STORAGE_CAPTURE_CLOCK_IN(STORAGE_CAPTURE_CLOCK_IN), .STAGE_PORTS_OUT(STAGE_PORTS_OUT),
  .STAGE_PORTS_OE_N_OUT(STAGE_PORTS_OE_N_OUT), .LAST_STAGE_OUT(LAST_STAGE_OUT),
  .BVALID_OUT(BVALID_OUT)
);
`default_nettype wire

/* File: piso_shift_core_tb.sv */
// Self-checking bench of the shift block.
`timescale 1ns/10ps
`default_nettype none
`include "piso_regs.svh"

module piso_shift_core_tb;
  logic        clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, last;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  ports, oe_n, exp_st, w, port_bus;
  logic [16:0] seed = 17'h1_09E5;
  int          miscompares = 0, num_checks = 0;
  piso_pkg::pin_bus_s pins;
  always #5 clk = ~clk;
  assign port_bus = (ports & ~oe_n) | (pins.stage_ports & oe_n);
  piso_ctrl_model u_ctl (.CLK_IN(clk), .PINS_OUT(pins));
  piso_shift_core dut
  (
    .CLK_IN(clk), .NRST_IN(nrst), .PARALLEL_DATA_IN(pins.parallel_data),
    .STORAGE_CAPTURE_CLOCK_IN(pins.storage_capture_clock), .SHIFT_CLOCK_IN(pins.shift_clock_in),
    .PARALLEL_LOAD_N_IN(pins.parallel_load_n), .SHIFT_CLEAR_N_IN(pins.shift_clear_n),
    .SHIFT_CLOCK_ENABLE_N_IN(pins.shift_clock_enable_n), .SHIFT_DATA_IN(pins.shift_data_in),
    .SERIAL_SOURCE_SELECT_IN(pins.serial_source_select), .OUTPUT_DRIVE_N_IN(pins.output_drive_n),
    .STAGE_PORTS_IN(port_bus), .STAGE_PORTS_OUT(ports), .STAGE_PORTS_OE_N_OUT(oe_n),
    .LAST_STAGE_OUT(last), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr),
    .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
    .RVALID_OUT(rvalid), .RREADY_IN(rready)
  );
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : nxt
  function automatic logic [31:0] stat(input logic [7:0] so, input logic [7:0] st, input logic oe);
    return {14'h0000, oe, st[7], st, so};
  endfunction : stat
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Readies are judged at the falling edge, where they are settled.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                           output logic [1:0] rs);
    logic aw_go;
    logic w_go;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    while ((awvalid && !aw_go) || (wvalid && !w_go));
    do @(negedge clk); while (!bvalid);
    rs = bresp;
    @(posedge clk);
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    v = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    axi_read(`PISO_STATUS_OFFSET, d, r);
    check("status", stat(8'h00, 8'h00, 1'b1), d);
    axi_read(4'h8, d, r);
    check("rresp", 32'(`PISO_RESP_SLVERR), 32'(r));
    axi_write(4'hC, 32'h0000_0003, 4'hF, r);
    check("bresp", 32'(`PISO_RESP_SLVERR), 32'(r));
    u_ctl.mode(1'b0, 1'b1);
    exp_st = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      seed = nxt(seed);
      w = (i == 0) ? 8'h80 : seed[7:0];
      u_ctl.capture(w);
      axi_read(`PISO_STATUS_OFFSET, d, r);
      check("capture", stat(w, exp_st, 1'b1), d);
      // The shift edge lands in the last load cycle, so a weak load priority shows.
      fork
        u_ctl.load();
        begin
          u_ctl.tick(2);
          u_ctl.shift(~w[0], 1'b0);
        end
      join
      exp_st = w;
      check("load", 32'(exp_st), 32'(ports));
      for (int k = 0; k < 8; k++)
      begin
        seed = nxt(seed);
        u_ctl.shift(seed[0], 1'b0);
        exp_st = {exp_st[6:0], seed[0]};
        check("shift", 32'({exp_st[7], exp_st}), 32'({last, ports}));
        if (i == 1 && k == 3)
        begin
          u_ctl.clear();
          exp_st = 8'h00;
          check("clear", 32'h0000_0000, 32'({last, ports}));
        end
      end
    end
    axi_write(`PISO_CTRL_OFFSET, 32'h0000_0001, 4'hF, r);
    check("bresp ok", 32'(`PISO_RESP_OKAY), 32'(r));
    axi_read(`PISO_CTRL_OFFSET, d, r);
    check("ctrl", 32'h0000_0001, d);
    check("rresp ok", 32'(`PISO_RESP_OKAY), 32'(r));
    u_ctl.mode(1'b1, 1'b0);
    check("oe on", 32'h0000_0000, 32'(oe_n));
    u_ctl.mode(1'b1, 1'b1);
    check("oe off", 32'h0000_00FF, 32'(oe_n));
    u_ctl.capture(8'h5A);
    u_ctl.load();
    u_ctl.shift(1'b1, 1'b0);
    check("gated", 32'h0000_005A, 32'(ports));
    u_ctl.mode(1'b0, 1'b1);
    exp_st = 8'h5A;
    for (int k = 0; k < 4; k++)
    begin
      u_ctl.shift(k[0], k[1]);
      exp_st = {exp_st[6:0], k[0]};
      check("select", 32'(exp_st), 32'(ports));
    end
    axi_write(`PISO_CTRL_OFFSET, 32'h0000_0003, 4'h0, r);
    repeat (3) @(posedge clk);
    check("strobe", 32'(exp_st), 32'(ports));
    axi_write(`PISO_CTRL_OFFSET, 32'h0000_0003, 4'hF, r);
    repeat (3) @(posedge clk);
    check("soft", 32'h0000_0000, 32'({last, ports}));
    axi_read(`PISO_CTRL_OFFSET, d, r);
    check("ctrl soft", 32'h0000_0003, d);
    axi_write(`PISO_STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF, r);
    check("ro", 32'(`PISO_RESP_OKAY), 32'(r));
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule : piso_shift_core_tb
`default_nettype wire
